// [core/hpfs_defines.vh]
/*
  Timing constants and gate drive codes for the two-rail hot-plug
  fault sequencer.
  Assumes a 40 MHz system clock; counts derive from times in ns.
*/
`ifndef HPFS_DEFINES_VH
`define HPFS_DEFINES_VH

`define HPFS_CLK_NS 25
`define HPFS_DEBOUNCE_NS 10000000
`define HPFS_BLANK_NS 5000000
`define HPFS_GLITCH_NS 100000
`define HPFS_LOW_UV_NS 8000
`define HPFS_MAIN_UV_NS 12000
`define HPFS_CLEAR_NS 20000
`define HPFS_POWERUP_NS 160000000
`define HPFS_FAST_NS 1000
`define HPFS_RETRY_MS 4000
`define HPFS_MS_NS 1000000

`define HPFS_DEBOUNCE_CYC (`HPFS_DEBOUNCE_NS / `HPFS_CLK_NS)
`define HPFS_BLANK_CYC (`HPFS_BLANK_NS / `HPFS_CLK_NS)
`define HPFS_GLITCH_CYC ((`HPFS_GLITCH_NS + `HPFS_CLK_NS - 1) / `HPFS_CLK_NS)
`define HPFS_LOW_UV_CYC ((`HPFS_LOW_UV_NS + `HPFS_CLK_NS - 1) / `HPFS_CLK_NS)
`define HPFS_MAIN_UV_CYC ((`HPFS_MAIN_UV_NS + `HPFS_CLK_NS - 1) / `HPFS_CLK_NS)
`define HPFS_CLEAR_CYC ((`HPFS_CLEAR_NS + `HPFS_CLK_NS - 1) / `HPFS_CLK_NS)
`define HPFS_POWERUP_CYC (`HPFS_POWERUP_NS / `HPFS_CLK_NS)
`define HPFS_FAST_CYC (`HPFS_FAST_NS / `HPFS_CLK_NS)
`define HPFS_MS_CYC (`HPFS_MS_NS / `HPFS_CLK_NS)

`define HPFS_GATE_OFF 2'h0
`define HPFS_GATE_CHARGE 2'h1
`define HPFS_GATE_PULL 2'h2
`define HPFS_GATE_FAST 2'h3

`endif

// [core/hpfs_sync.v]
/*
  Two-flop synchroniser for one comparator level.
  Assumes the level is slow relative to the clock.
*/
`timescale 1ns/10ps
`default_nettype none
module hpfs_sync #(
  parameter RESET_VAL = 1'b0
) (
  input wire sys_clk_i,
  input wire resetn_i,
  input wire clk_en_i,
  input wire async_i,
  output reg sync_o
);
  reg stage;

  // ==========================================================
  // Synchroniser.
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stage <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else if (clk_en_i) begin
      stage <= async_i;
      sync_o <= stage;
    end
  end
endmodule
`default_nettype wire

// [core/hpfs_channel.v]
/*
  One channel: debounce, start-up blanking, overcurrent filter,
  breaker blanking and armed window, latch-off and auto-retry.
  Assumes synchronised inputs and a shared 1 ms tick.
*/
`timescale 1ns/10ps
`default_nettype none
`include "hpfs_defines.vh"
module hpfs_channel #(
  parameter AUTO_RETRY = 0,
  parameter DEBOUNCE_CYC = `HPFS_DEBOUNCE_CYC,
  parameter BLANK_CYC = `HPFS_BLANK_CYC,
  parameter RETRY_MS = `HPFS_RETRY_MS
) (
  input wire sys_clk_i,
  input wire resetn_i,
  input wire clk_en_i,
  input wire ms_tick_i,
  input wire enable_n_i,
  input wire rail_ok_i,
  input wire main_ok_i,
  input wire breaker_i,
  input wire short_i,
  output reg [1:0] gate_o,
  output wire fault_o
);
  localparam ST_RESET = 3'h0;
  localparam ST_DEBOUNCE = 3'h1;
  localparam ST_STARTUP = 3'h2;
  localparam ST_IDLE = 3'h3;
  localparam ST_BLANK = 3'h4;
  localparam ST_ARMED = 3'h5;
  localparam ST_FAULT = 3'h6;
  localparam integer FAST_INT = `HPFS_FAST_CYC;
  localparam [5:0] FAST_CYC = FAST_INT[5:0];

  reg [2:0] state;
  reg [2:0] next_state;
  reg [22:0] timer;
  reg [12:0] glitch;
  reg [10:0] clear_cnt;
  reg [5:0] fast_cnt;
  reg [12:0] retry_ms;
  reg short_d;
  wire oc_long;
  wire hold_off;
  wire cleared;
  wire retry_done;

  assign oc_long = (glitch == `HPFS_GLITCH_CYC);
  assign hold_off = enable_n_i || !rail_ok_i || !main_ok_i;
  assign cleared = (clear_cnt == `HPFS_CLEAR_CYC);
  assign retry_done = (AUTO_RETRY != 0) && (retry_ms == RETRY_MS);
  assign fault_o = (state == ST_FAULT);

  // ==========================================================
  // Next state.
  always @* begin
    next_state = state;
    case (state)
      ST_RESET: begin
        if (!hold_off)
          next_state = ST_DEBOUNCE; // [RULE4]
      end
      ST_DEBOUNCE: begin
        if (hold_off)
          next_state = ST_RESET; // [RULE5]
        else if (timer == DEBOUNCE_CYC)
          next_state = ST_STARTUP; // [RULE4] [RULE6]
      end
      ST_STARTUP: begin
        if (timer == BLANK_CYC)
          next_state = breaker_i ? ST_FAULT : ST_IDLE; // [RULE7]
      end
      ST_IDLE: begin
        if (oc_long)
          next_state = ST_BLANK; // [RULE8] [RULE9]
      end
      ST_BLANK: begin
        if (timer == BLANK_CYC)
          next_state = ST_ARMED; // [RULE10]
      end
      ST_ARMED: begin
        if (oc_long)
          next_state = ST_FAULT; // [RULE10] [RULE13]
        else if (timer == BLANK_CYC)
          next_state = ST_IDLE; // [RULE11]
      end
      ST_FAULT: begin
        if (cleared)
          next_state = ST_RESET; // [RULE17]
        else if (retry_done)
          next_state = ST_RESET; // [RULE21] [RULE23]
      end
      default: next_state = ST_RESET;
    endcase
    // Supply loss drops the channel, fault cleared; enable high drops it in every state except fault.
    if (!rail_ok_i || !main_ok_i)
      next_state = ST_RESET; // [RULE15] [RULE16] [RULE18] [RULE20]
    else if (enable_n_i && state != ST_FAULT)
      next_state = ST_RESET; // [RULE1] [RULE3]
  end

  // ==========================================================
  // State, timers and filters.
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= ST_RESET;
      timer <= 23'h000000;
      glitch <= 13'h0000;
      clear_cnt <= 11'h000;
      retry_ms <= 13'h0000;
      fast_cnt <= 6'h00;
      short_d <= 1'b0;
    end else if (clk_en_i) begin
      state <= next_state;
      if (next_state != state)
        timer <= 23'h000000;
      else
        timer <= timer + 23'h000001;
      if (!breaker_i || state == ST_BLANK || next_state != state)
        glitch <= 13'h0000; // [RULE8]
      else if (!oc_long)
        glitch <= glitch + 13'h0001;
      if (state != ST_FAULT || !enable_n_i)
        clear_cnt <= 11'h000;
      else if (!cleared)
        clear_cnt <= clear_cnt + 11'h001; // [RULE17]
      if (state != ST_FAULT)
        retry_ms <= 13'h0000;
      else if (ms_tick_i && !retry_done)
        retry_ms <= retry_ms + 13'h0001; // [RULE21]
      short_d <= short_i;
      if (short_i && !short_d && state != ST_RESET &&
          state != ST_DEBOUNCE && state != ST_FAULT)
        fast_cnt <= FAST_CYC; // [RULE12]
      else if (fast_cnt != 6'h00)
        fast_cnt <= fast_cnt - 6'h01;
    end
  end

  // ==========================================================
  // Gate drive, one mode at a time.
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i)
      gate_o <= `HPFS_GATE_PULL;
    else if (clk_en_i) begin
      case (next_state)
        ST_RESET, ST_DEBOUNCE, ST_FAULT: gate_o <= `HPFS_GATE_PULL; // [RULE24]
        default: begin
          if (fast_cnt != 6'h00)
            gate_o <= `HPFS_GATE_FAST; // [RULE12]
          else
            gate_o <= `HPFS_GATE_CHARGE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [core/hpfs_top.v]
/*
  Two-rail hot-plug fault sequencer top: input synchronisers, main
  supply lockout with turn-on delay, shared 1 ms time base, two
  channel instances and the shared open-drain fault flag.
  Assumes comparator levels arrive asynchronously and enables are
  synchronous to sys_clk_i.
*/
// What this block does
// RULE1: Enable high turns that channel off with normal pull-down only.
// RULE2: Channels are independent; only lockout and fault flag are shared.
// RULE3: Enable high holds the channel in reset, switch off.
// RULE4: Enable low starts 10 ms debounce, then gate charging.
// RULE5: Enable high or rail loss during debounce abandons and restarts it.
// RULE6: Charging starts 5 ms start-up blanking; no latch-off meanwhile.
// RULE7: Breaker still tripped after start-up blanking latches channel off.
// RULE8: After start-up, overcurrent under 100 us is ignored.
// RULE9: Overcurrent beyond 100 us starts 5 ms breaker blanking, channel on.
// RULE10: Then 5 ms armed; a 100 us overcurrent latches off.
// RULE11: Quiet armed window returns to idle monitoring.
// RULE12: Severe short fires brief fast discharge, then normal regulation.
// RULE13: Breaker trip turns channel off and pulls fault flag low.
// RULE14: Fault flag low if either channel tripped, otherwise released.
// RULE15: Rail below low level over 8 us: channel off, fault cleared.
// RULE16: Main supply low over 12 us: both off, faults cleared.
// RULE17: Enable held high 20 us clears fault and restarts turn-on.
// RULE18: Lower rail undervoltage clears own fault, restarts without delay.
// RULE19: Main undervoltage clears both; restart after 160 ms delay.
// RULE20: With both rails healthy, a rail dropout resets only its fault.
// RULE21: Auto-retry clears a fault after four seconds; else stay latched.
// RULE22: Both channels disabled until main supply good for 160 ms.
// RULE23: Retry mode is a build parameter; delays share one time base.
// RULE24: Comparators synchronised; gate drive modes mutually exclusive.
`timescale 1ns/10ps
`default_nettype none
`include "hpfs_defines.vh"
module hpfs_top #(
  parameter AUTO_RETRY = 0,
  parameter POWERUP_CYC = `HPFS_POWERUP_CYC,
  parameter DEBOUNCE_CYC = `HPFS_DEBOUNCE_CYC,
  parameter BLANK_CYC = `HPFS_BLANK_CYC,
  parameter MS_CYC = `HPFS_MS_CYC,
  parameter RETRY_MS = `HPFS_RETRY_MS
) (
  input wire sys_clk_i,
  input wire resetn_i,
  input wire clk_en_i,
  input wire enable_ch1_n_i,
  input wire enable_ch2_n_i,
  input wire rail_one_ok_i,
  input wire rail_two_ok_i,
  input wire main_ok_i,
  input wire breaker_ch1_i,
  input wire breaker_ch2_i,
  input wire short_ch1_i,
  input wire short_ch2_i,
  output wire [1:0] gate_ch1_o,
  output wire [1:0] gate_ch2_o,
  output wire fault_n_o,
  output wire fault_n_oe_o
);
  wire [6:0] raw_in;
  wire [6:0] syn;
  wire [1:0] fault;
  reg [8:0] uv1_cnt;
  reg [8:0] uv2_cnt;
  reg [9:0] main_uv_cnt;
  reg [22:0] power_cnt;
  reg [15:0] ms_cnt;
  reg ms_tick;
  reg main_ok;
  reg rail1_ok;
  reg rail2_ok;

  assign raw_in = {short_ch2_i, short_ch1_i, breaker_ch2_i,
    breaker_ch1_i, main_ok_i, rail_two_ok_i, rail_one_ok_i};

  // ==========================================================
  // Comparator synchronisers.
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_sync
      hpfs_sync u_sync (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .clk_en_i(clk_en_i),
        .async_i(raw_in[gi]),
        .sync_o(syn[gi])
      ); // [RULE24]
    end
  endgenerate

  // ==========================================================
  // Undervoltage filters and main supply turn-on delay.
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      uv1_cnt <= 9'h000;
      uv2_cnt <= 9'h000;
      main_uv_cnt <= 10'h000;
      power_cnt <= 23'h000000;
      rail1_ok <= 1'b0;
      rail2_ok <= 1'b0;
      main_ok <= 1'b0;
    end else if (clk_en_i) begin
      if (syn[0]) begin
        uv1_cnt <= 9'h000;
        rail1_ok <= 1'b1; // [RULE18]
      end else if (uv1_cnt == `HPFS_LOW_UV_CYC)
        rail1_ok <= 1'b0; // [RULE15]
      else
        uv1_cnt <= uv1_cnt + 9'h001;
      if (syn[1]) begin
        uv2_cnt <= 9'h000;
        rail2_ok <= 1'b1; // [RULE18]
      end else if (uv2_cnt == `HPFS_LOW_UV_CYC)
        rail2_ok <= 1'b0; // [RULE15]
      else
        uv2_cnt <= uv2_cnt + 9'h001;
      if (syn[2]) begin
        main_uv_cnt <= 10'h000;
        if (power_cnt == POWERUP_CYC)
          main_ok <= 1'b1; // [RULE19] [RULE22]
        else
          power_cnt <= power_cnt + 23'h000001;
      end else if (main_uv_cnt == `HPFS_MAIN_UV_CYC) begin
        main_ok <= 1'b0; // [RULE16]
        power_cnt <= 23'h000000; // [RULE19]
      end else
        main_uv_cnt <= main_uv_cnt + 10'h001;
    end
  end

  // ==========================================================
  // Shared free-running millisecond time base.
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ms_cnt <= 16'h0000;
      ms_tick <= 1'b0;
    end else if (clk_en_i) begin
      ms_tick <= (ms_cnt == MS_CYC - 1); // [RULE23]
      if (ms_cnt == MS_CYC - 1)
        ms_cnt <= 16'h0000;
      else
        ms_cnt <= ms_cnt + 16'h0001;
    end
  end

  // ==========================================================
  // Channel instances.
  hpfs_channel #(
    .AUTO_RETRY(AUTO_RETRY),
    .DEBOUNCE_CYC(DEBOUNCE_CYC),
    .BLANK_CYC(BLANK_CYC),
    .RETRY_MS(RETRY_MS)
  ) u_ch1 (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .clk_en_i(clk_en_i),
    .ms_tick_i(ms_tick),
    .enable_n_i(enable_ch1_n_i),
    .rail_ok_i(rail1_ok),
    .main_ok_i(main_ok),
    .breaker_i(syn[3]),
    .short_i(syn[5]),
    .gate_o(gate_ch1_o),
    .fault_o(fault[0])
  ); // [RULE2]

  hpfs_channel #(
    .AUTO_RETRY(AUTO_RETRY),
    .DEBOUNCE_CYC(DEBOUNCE_CYC),
    .BLANK_CYC(BLANK_CYC),
    .RETRY_MS(RETRY_MS)
  ) u_ch2 (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .clk_en_i(clk_en_i),
    .ms_tick_i(ms_tick),
    .enable_n_i(enable_ch2_n_i),
    .rail_ok_i(rail2_ok),
    .main_ok_i(main_ok),
    .breaker_i(syn[4]),
    .short_i(syn[6]),
    .gate_o(gate_ch2_o),
    .fault_o(fault[1])
  ); // [RULE2]

  // ==========================================================
  // Shared open-drain fault flag.
  assign fault_n_o = 1'b0;
  assign fault_n_oe_o = fault[0] | fault[1]; // [RULE14] [RULE13]
endmodule
`default_nettype wire

// [test/hpfs_top_asserts.sv]
/* Port-level assertions for the two-rail hot-plug fault sequencer.
   Assumes it is bound into hpfs_top and shares its debounce count. */
`timescale 1ns/10ps
`default_nettype none
module hpfs_top_asserts #(
  parameter DEBOUNCE_CYC = 40
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic enable_ch1_n_i,
  input wire logic enable_ch2_n_i,
  input wire logic rail_one_ok_i,
  input wire logic main_ok_i,
  input wire logic breaker_ch1_i,
  input wire logic breaker_ch2_i,
  input wire logic short_ch2_i,
  input wire logic [1:0] gate_ch1_o,
  input wire logic [1:0] gate_ch2_o,
  input wire logic fault_n_o,
  input wire logic fault_n_oe_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // ==========
  // Saturating counts of how long each level has been low.
  logic [23:0] en1_low;
  logic [23:0] rail1_low;
  logic [23:0] main_low;
  function automatic logic [23:0] nxt(input logic clr, input logic [23:0] c);
    return clr ? 24'h000000 : c + {23'h000000, ~&c};
  endfunction
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en1_low <= 24'h000000;
      rail1_low <= 24'h000000;
      main_low <= 24'h000000;
    end else begin
      en1_low <= nxt(enable_ch1_n_i, en1_low);
      rail1_low <= nxt(rail_one_ok_i, rail1_low);
      main_low <= nxt(main_ok_i, main_low);
    end
  end
  // ==========
  // Assertions.
  AST_GATE_CODE: assert property (
    gate_ch1_o != 2'h0 && gate_ch2_o != 2'h0)
    else $error("gate code unused value");
  AST_EN1_OFF: assert property (
    enable_ch1_n_i [*4] |-> gate_ch1_o == 2'h2)
    else $error("channel one on while disabled");
  AST_EN2_OFF: assert property (
    enable_ch2_n_i [*4] |-> gate_ch2_o == 2'h2)
    else $error("channel two on while disabled");
  AST_DEBOUNCE: assert property (
    $past(gate_ch1_o) == 2'h2 && gate_ch1_o == 2'h1
    |-> en1_low >= DEBOUNCE_CYC) else $error("charge before debounce");
  AST_TRIP_CAUSE: assert property ($rose(fault_n_oe_o) |->
    (gate_ch1_o == 2'h2 || gate_ch2_o == 2'h2) &&
    ($past(breaker_ch1_i, 3) || $past(breaker_ch2_i, 3)))
    else $error("fault without breaker trip");
  AST_FLAG_LOW: assert property (
    fault_n_oe_o |-> fault_n_o == 1'b0)
    else $error("fault pin driven high");
  AST_FAST: assert property (
    gate_ch2_o == 2'h1 && $rose(short_ch2_i)
    |-> ##[1:6] gate_ch2_o == 2'h3) else $error("no fast discharge");
  AST_FAST_HOLD: assert property ($rose(gate_ch2_o == 2'h3)
    |-> (gate_ch2_o == 2'h3) [*8]) else $error("fast discharge too short");
  AST_RAIL_UV: assert property (
    rail1_low >= 24'h00014A |-> gate_ch1_o == 2'h2)
    else $error("channel one on with rail low");
  AST_MAIN_UV: assert property (main_low >= 16'h01EA
    |-> gate_ch1_o == 2'h2 && gate_ch2_o == 2'h2)
    else $error("channel on with main supply low");
  cover property ($rose(fault_n_oe_o));
  cover property ($fell(fault_n_oe_o));
  cover property (gate_ch2_o == 2'h3);
endmodule
bind hpfs_top hpfs_top_asserts #(.DEBOUNCE_CYC(DEBOUNCE_CYC))
  hpfs_top_asserts_inst (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
  .enable_ch1_n_i(enable_ch1_n_i), .enable_ch2_n_i(enable_ch2_n_i),
  .rail_one_ok_i(rail_one_ok_i), .main_ok_i(main_ok_i),
  .breaker_ch1_i(breaker_ch1_i), .breaker_ch2_i(breaker_ch2_i),
  .short_ch2_i(short_ch2_i), .gate_ch1_o(gate_ch1_o),
  .gate_ch2_o(gate_ch2_o), .fault_n_o(fault_n_o), .fault_n_oe_o(fault_n_oe_o));
`default_nettype wire

// [test/hpfs_load_model.sv]
/* Two external switches with sense comparators, and the fault line.
   Assumes the gate codes that the sequencer drives. */
`timescale 1ns/10ps
`default_nettype none
module hpfs_load_model (
  input wire logic [1:0] gate_ch1_i,
  input wire logic [1:0] gate_ch2_i,
  input wire logic [1:0] overload_i,
  input wire logic [1:0] severe_i,
  input wire logic fault_n_i,
  input wire logic fault_n_oe_i,
  output logic [1:0] breaker_o,
  output logic [1:0] short_o,
  output logic fault_line_o
);
  // ==========
  // A switch carries load current unless its gate is pulled down.
  logic [1:0] conducting;
  assign conducting = {gate_ch2_i != 2'h2, gate_ch1_i != 2'h2};
  assign breaker_o = overload_i & conducting;
  assign short_o = severe_i & conducting;
  // The pull-up holds the line high while the pin is released.
  assign fault_line_o = fault_n_oe_i ? fault_n_i : 1'b1;
endmodule
`default_nettype wire

// [test/tb.sv]
/* Self-checking bench for the two-rail hot-plug fault sequencer.
   Assumes shortened timing parameters and the load model on the far side. */
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int PWR = 50;
  localparam int DEB = 40;
  localparam int BLK = 4500;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic en1_n = 1'b0;
  logic en2_n = 1'b1;
  logic r1 = 1'b1;
  logic r2 = 1'b1;
  logic mok = 1'b1;
  logic cen = 1'b1;
  logic [1:0] ovl = 2'h0;
  logic [1:0] sev = 2'h0;
  logic [1:0] brk;
  logic [1:0] sh;
  logic [1:0] g1;
  logic [1:0] g2;
  logic fn;
  logic foe;
  logic fline;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  always #12.5 clk = ~clk;
  hpfs_top #(.POWERUP_CYC(PWR), .DEBOUNCE_CYC(DEB), .BLANK_CYC(BLK),
    .MS_CYC(10), .RETRY_MS(4)) hpfs_top_inst (
    .sys_clk_i(clk), .resetn_i(rstn), .clk_en_i(cen),
    .enable_ch1_n_i(en1_n), .enable_ch2_n_i(en2_n),
    .rail_one_ok_i(r1), .rail_two_ok_i(r2), .main_ok_i(mok),
    .breaker_ch1_i(brk[0]), .breaker_ch2_i(brk[1]),
    .short_ch1_i(sh[0]), .short_ch2_i(sh[1]), .gate_ch1_o(g1),
    .gate_ch2_o(g2), .fault_n_o(fn), .fault_n_oe_o(foe));
  hpfs_load_model hpfs_load_model_inst (
    .gate_ch1_i(g1), .gate_ch2_i(g2), .overload_i(ovl), .severe_i(sev),
    .fault_n_i(fn), .fault_n_oe_i(foe), .breaker_o(brk), .short_o(sh),
    .fault_line_o(fline));
  // ==========
  // Shared tasks.
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  task automatic chk(input string what, input logic [15:0] e,
    input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %0h seen %0h", what, e, s);
    end
  endtask
  task automatic wait_gate(input int ch, input logic [1:0] code,
    input int lim);
    n = 0;
    while ((ch == 1 ? g1 : g2) !== code && n < lim) begin
      step(1);
      n++;
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (num_checks > 0 && bad_count == 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ==========
  // Scenarios.
  task automatic t_powerup;
    step(30);
    chk("gate1 in supply delay", 2'h2, g1);
    wait_gate(1, 2'h1, 200);
    chk("gate1 on", 2'h1, g1);
    chk("turn-on time", 1, n + 30 >= PWR + DEB);
  endtask
  task automatic t_bounce;
    en2_n = 1'b0;
    step(20);
    en2_n = 1'b1;
    step(2);
    en2_n = 1'b0;
    wait_gate(2, 2'h1, 200);
    chk("gate2 on", 2'h1, g2);
    chk("debounce restarted", 1, n >= DEB);
  endtask
  task automatic t_start_fault;
    ovl[0] = 1'b1;
    en1_n = 1'b1;
    step(10);
    chk("gate1 off", 2'h2, g1);
    chk("gate2 kept", 2'h1, g2);
    en1_n = 1'b0;
    wait_gate(1, 2'h1, 200);
    step(BLK - 100);
    chk("gate1 in blanking", 2'h1, g1);
    wait_gate(1, 2'h2, 300);
    chk("gate1 latched", 2'h2, g1);
    chk("fault line", 0, fline);
    step(100);
    chk("fault stays latched", 0, fline);
    en1_n = 1'b1;
    step(400);
    chk("fault kept", 0, fline);
    step(500);
    chk("fault released", 1, fline);
    ovl[0] = 1'b0;
    en1_n = 1'b0;
    wait_gate(1, 2'h1, 200);
    chk("gate1 restarted", 2'h1, g1);
  endtask
  task automatic t_overcurrent;
    step(BLK + 10);
    ovl[0] = 1'b1;
    step(3000);
    ovl[0] = 1'b0;
    step(10);
    chk("glitch ignored", 2'h1, g1);
    ovl[0] = 1'b1;
    step(4100);
    chk("gate1 on in blanking", 2'h1, g1);
    ovl[0] = 1'b0;
    step(4500);
    ovl[0] = 1'b1;
    wait_gate(1, 2'h2, 4300);
    chk("armed trip", 2'h2, g1);
    chk("armed filter", 1, n >= 3900);
    chk("fault on armed trip", 0, fline);
    ovl[0] = 1'b0;
  endtask
  task automatic t_rail;
    r1 = 1'b0;
    step(340);
    chk("gate1 rail low", 2'h2, g1);
    chk("fault cleared", 1, fline);
    chk("gate2 untouched", 2'h1, g2);
    r1 = 1'b1;
    wait_gate(1, 2'h1, 60);
    chk("gate1 no supply delay", 2'h1, g1);
  endtask
  task automatic t_short;
    sev[1] = 1'b1;
    wait_gate(2, 2'h3, 8);
    chk("fast discharge", 2'h3, g2);
    wait_gate(2, 2'h1, 60);
    chk("back to charge", 2'h1, g2);
    chk("fast length", 1, n >= 30);
    sev[1] = 1'b0;
  endtask
  task automatic t_main;
    mok = 1'b0;
    step(500);
    chk("gate1 main low", 2'h2, g1);
    chk("gate2 main low", 2'h2, g2);
    mok = 1'b1;
    step(40);
    chk("gate1 in delay", 2'h2, g1);
    wait_gate(1, 2'h1, 100);
    chk("gate1 after delay", 2'h1, g1);
  endtask
  task automatic t_freeze;
    en2_n = 1'b1;
    step(2);
    chk("gate2 disabled", 2'h2, g2);
    cen = 1'b0;
    en2_n = 1'b0;
    step(100);
    chk("gate2 frozen", 2'h2, g2);
    cen = 1'b1;
    wait_gate(2, 2'h1, 60);
    chk("gate2 on after freeze", 2'h1, g2);
    chk("debounce after freeze", 1, n >= DEB);
  endtask
  // ==========
  // Timeout and main sequence.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      results();
    end
  end
  initial begin
    step(3);
    rstn = 1'b1;
    t_powerup();
    t_bounce();
    t_start_fault();
    t_overcurrent();
    t_rail();
    t_short();
    t_main();
    t_freeze();
    results();
  end
endmodule
`default_nettype wire
